// *** include/rx_manager_cfg.svh ***
// named numbers for the receiver lock and calibration manager
// assumes a 200 MHz aclk and a 32-bit AXI4-Lite register port
`ifndef RX_MANAGER_CFG_SVH
`define RX_MANAGER_CFG_SVH

// ---------------------------------------------------------------------------
// timing
// ---------------------------------------------------------------------------
`define CLK_PERIOD_NS   5
`define CLK_PERIOD_PS   5000
`define LOCK_WAIT_NS    300000
`define TIMER_W         17

// ---------------------------------------------------------------------------
// register map
// ---------------------------------------------------------------------------
`define ADDR_W          4
`define CTRL_OFS        4'h0
`define STAT_OFS        4'h4
`define CTRL_W          4
`define CTRL_RST        4'h3
`define CTRL_FIRST_BIT  0
`define CTRL_DEMAND_BIT 1
`define CTRL_EYE_BIT    2
`define CTRL_COEFF_BIT  3
`define STAT_W          10
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// *** include/rx_manager_pkg.sv ***
// types for the receiver lock and calibration manager
// assumes rx_manager_cfg.svh is on the include path
`include "rx_manager_cfg.svh"

package rx_manager_pkg;

  // gray order along ref -> acquire -> locked -> calibrate
  typedef enum logic [1:0] {
    ST_REF    = 2'h0,
    ST_ACQ    = 2'h1,
    ST_LOCKED = 2'h3,
    ST_CAL    = 2'h2
  } lock_state_e;

  typedef enum logic [1:0] {
    OP_FULL  = 2'h0,
    OP_EYE   = 2'h1,
    OP_COEFF = 2'h2
  } cal_op_e;

  typedef struct packed {
    lock_state_e          st;
    cal_op_e              op;
    logic [`TIMER_W-1:0]  tmr;
    logic [1:0]           los_s;
    logic [1:0]           act_s;
    logic [1:0]           lock_s;
    logic [2:0]           req_s;
    logic [2:0]           eye_s;
    logic [2:0]           coeff_s;
    logic [2:0]           cdone_s;
    logic [2:0]           edone_s;
    logic [2:0]           kdone_s;
    logic                 cal_pend;
    logic                 eye_pend;
    logic                 coeff_pend;
    logic                 first_done;
    logic                 cal_once;
    logic                 eye_cmp;
    logic                 coeff_cmp;
    logic                 cal_go;
    logic                 eye_go;
    logic                 coeff_go;
    logic                 valid;
    logic [`CTRL_W-1:0]   ctrl;
    logic                 aw_have;
    logic                 w_have;
    logic [`ADDR_W-1:0]   waddr;
    logic [31:0]          wdata;
    logic                 wstrb0;
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 rvalid;
    logic [31:0]          rdata;
    logic [1:0]           rresp;
  } mgr_s;

endpackage : rx_manager_pkg

// *** hw/receiver_manager.sv ***
// receiver lock and calibration manager for one transceiver lane
// assumes lane status inputs are asynchronous and the lane engines pulse or
// raise their done lines after a start pulse; software on AXI4-Lite
//
// What this block does
// - choose lock-to-reference or lock-to-data mode
// - auto calibrate on first data lock
// - on-demand calibration when user requests
// - eye request runs clock-centering recalibration
// - separate incremental equalizer coefficient recalibration
// - calibrating high while calibration runs
// - signal loss holds lock-to-reference
// - signal loss ignored once in lock-to-data
// - calibration request acts on rising edge
// - data valid only when locked and idle
// - no-activity output low means input activity
// - fine lock output follows lane lock window
// - lock may take about three times longer
// - delayed traffic and cable pull handled alone
// - calibrating rises on request, falls when done
// - eye recalibration complete flag
// - coefficient request starts incremental recalibration
// - coefficient recalibration complete flag
//
// Added by the designer: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "rx_manager_cfg.svh"

module receiver_manager
  import rx_manager_pkg::*;
#(
  parameter logic [`TIMER_W-1:0] LOCK_WAIT_CYC =
    `TIMER_W'(`LOCK_WAIT_NS * 1000 / `CLK_PERIOD_PS)
) (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic [`ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [`ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  input  wire logic                signal_loss_in,
  input  wire logic                cal_request,
  input  wire logic                eye_recal_request,
  input  wire logic                coeff_recal_request,
  input  wire logic                peak_activity_in,
  input  wire logic                fine_lock_in,
  input  wire logic                cal_done_in,
  input  wire logic                eye_done_in,
  input  wire logic                coeff_done_in,
  output logic                     lock_to_data,
  output logic                     cal_start,
  output logic                     eye_start,
  output logic                     coeff_start,
  output logic                     calibrating,
  output logic                     rx_data_valid,
  output logic                     rx_ready,
  output logic                     rx_no_activity,
  output logic                     eye_recal_complete,
  output logic                     coeff_recal_complete
);
  import rx_manager_pkg::*;

  mgr_s q;
  mgr_s n;

  // -------------------------------------------------------------------------
  // synchronised views and edges
  // -------------------------------------------------------------------------
  logic los;
  logic act;
  logic lock;
  logic req_rise;
  logic eye_rise;
  logic coeff_rise;
  logic cdone_rise;
  logic edone_rise;
  logic kdone_rise;
  logic [`STAT_W-1:0] status;

  assign los        = q.los_s[1];
  assign act        = q.act_s[1];
  assign lock       = q.lock_s[1];
  assign req_rise   = q.req_s[1] & ~q.req_s[2];
  assign eye_rise   = q.eye_s[1] & ~q.eye_s[2];
  assign coeff_rise = q.coeff_s[1] & ~q.coeff_s[2];
  assign cdone_rise = q.cdone_s[1] & ~q.cdone_s[2];
  assign edone_rise = q.edone_s[1] & ~q.edone_s[2];
  assign kdone_rise = q.kdone_s[1] & ~q.kdone_s[2];

  assign status = {q.cal_once, los, act, q.coeff_cmp, q.eye_cmp, calibrating,
                   q.valid, lock, q.st};

  // -------------------------------------------------------------------------
  // next state
  // -------------------------------------------------------------------------
  always_comb begin
    n = q;
    // stage 0 feeds only stage 1
    n.los_s   = {q.los_s[0], signal_loss_in};
    n.act_s   = {q.act_s[0], peak_activity_in};
    n.lock_s  = {q.lock_s[0], fine_lock_in};
    n.req_s   = {q.req_s[1:0], cal_request};
    n.eye_s   = {q.eye_s[1:0], eye_recal_request};
    n.coeff_s = {q.coeff_s[1:0], coeff_recal_request};
    n.cdone_s = {q.cdone_s[1:0], cal_done_in};
    n.edone_s = {q.edone_s[1:0], eye_done_in};
    n.kdone_s = {q.kdone_s[1:0], coeff_done_in};
    n.cal_go   = 1'b0;
    n.eye_go   = 1'b0;
    n.coeff_go = 1'b0;

    case (q.st)
      ST_REF: begin
        n.tmr = '0;
        // loss of signal only matters before the data lock is tried
        if (act && !los) begin
          n.st = ST_ACQ;
        end
      end
      ST_ACQ: begin
        // a missing or late stream drops back and retries from reference
        if (lock) begin
          n.st = ST_LOCKED;
          if (q.ctrl[`CTRL_FIRST_BIT] && !q.first_done) begin
            n.cal_pend   = 1'b1;
            n.first_done = 1'b1;
          end
        // the window must cover the slower lock of a managed lane
        end else if (q.tmr == LOCK_WAIT_CYC - `TIMER_W'(1)) begin
          n.st = ST_REF;
        end else begin
          n.tmr = q.tmr + `TIMER_W'(1);
        end
      end
      ST_LOCKED: begin
        if (!lock) begin
          n.st = ST_REF;
        end else if (q.cal_pend) begin
          n.st     = ST_CAL;
          n.op     = OP_FULL;
          n.cal_go = 1'b1;
        end else if (q.eye_pend) begin
          n.st     = ST_CAL;
          n.op     = OP_EYE;
          n.eye_go = 1'b1;
        end else if (q.coeff_pend) begin
          n.st       = ST_CAL;
          n.op       = OP_COEFF;
          n.coeff_go = 1'b1;
        end
      end
      ST_CAL: begin
        // the engine owns the lane until it reports done
        if (q.op == OP_FULL && cdone_rise) begin
          n.st       = ST_LOCKED;
          n.cal_pend = 1'b0;
          n.cal_once = 1'b1;
        end else if (q.op == OP_EYE && edone_rise) begin
          n.st       = ST_LOCKED;
          n.eye_pend = 1'b0;
          n.eye_cmp  = 1'b1;
        end else if (q.op == OP_COEFF && kdone_rise) begin
          n.st         = ST_LOCKED;
          n.coeff_pend = 1'b0;
          n.coeff_cmp  = 1'b1;
        end
      end
      default: begin
        n.st = ST_REF;
      end
    endcase

    // requests land after the clears so a same-cycle request survives
    if (req_rise && q.ctrl[`CTRL_DEMAND_BIT]) begin
      n.cal_pend = 1'b1;
    end
    // incremental work needs one full calibration behind it
    if (eye_rise && q.ctrl[`CTRL_EYE_BIT] && q.cal_once) begin
      n.eye_pend = 1'b1;
      n.eye_cmp  = 1'b0;
    end
    if (coeff_rise && q.ctrl[`CTRL_COEFF_BIT] && q.cal_once) begin
      n.coeff_pend = 1'b1;
      n.coeff_cmp  = 1'b0;
    end
    n.valid = (n.st == ST_LOCKED) && lock && !n.cal_pend && !n.eye_pend &&
              !n.coeff_pend;

    // -----------------------------------------------------------------------
    // AXI4-Lite slave: one write and one read outstanding
    // -----------------------------------------------------------------------
    if (s_axi_awvalid && s_axi_awready) begin
      n.aw_have = 1'b1;
      n.waddr   = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      n.w_have = 1'b1;
      n.wdata  = s_axi_wdata;
      n.wstrb0 = s_axi_wstrb[0];
    end
    if (q.aw_have && q.w_have) begin
      n.aw_have = 1'b0;
      n.w_have  = 1'b0;
      n.bvalid  = 1'b1;
      n.bresp   = `RESP_OKAY;
      if (q.waddr == `CTRL_OFS) begin
        if (q.wstrb0) begin
          n.ctrl = q.wdata[`CTRL_W-1:0];
        end
      end else if (q.waddr != `STAT_OFS) begin
        n.bresp = `RESP_SLVERR;
      end
    end
    if (q.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      n.rvalid = 1'b1;
      n.rresp  = `RESP_OKAY;
      n.rdata  = '0;
      if (s_axi_araddr == `CTRL_OFS) begin
        n.rdata[`CTRL_W-1:0] = q.ctrl;
      end else if (s_axi_araddr == `STAT_OFS) begin
        n.rdata[`STAT_W-1:0] = status;
      end else begin
        n.rresp = `RESP_SLVERR;
      end
    end else if (q.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
  end

  // -------------------------------------------------------------------------
  // state register
  // -------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q      <= '0;
      q.st   <= ST_REF;
      q.op   <= OP_FULL;
      q.ctrl <= `CTRL_RST;
    end else begin
      q <= n;
    end
  end

  // -------------------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------------------
  assign s_axi_awready        = !q.aw_have && !q.bvalid;
  assign s_axi_wready         = !q.w_have && !q.bvalid;
  assign s_axi_bvalid         = q.bvalid;
  assign s_axi_bresp          = q.bresp;
  assign s_axi_arready        = !q.rvalid;
  assign s_axi_rvalid         = q.rvalid;
  assign s_axi_rdata          = q.rdata;
  assign s_axi_rresp          = q.rresp;
  assign lock_to_data         = (q.st != ST_REF);
  assign cal_start            = q.cal_go;
  assign eye_start            = q.eye_go;
  assign coeff_start          = q.coeff_go;
  assign calibrating          = q.cal_pend | q.eye_pend | q.coeff_pend |
                                (q.st == ST_CAL);
  // lock is re-checked here so a lost lock drops valid in the same cycle
  assign rx_data_valid        = q.valid & lock;
  assign rx_ready             = lock;
  assign rx_no_activity       = ~act;
  assign eye_recal_complete   = q.eye_cmp;
  assign coeff_recal_complete = q.coeff_cmp;

  // -------------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------------
  los_holds_ref_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (q.st == ST_REF) && los |=> (q.st == ST_REF))
    else $error("left reference while signal loss set");

  los_ignored_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (q.st == ST_LOCKED) && lock && !q.cal_pend && !q.eye_pend && !q.coeff_pend
      && los |=> (q.st == ST_LOCKED))
    else $error("left data lock without lock loss");

  req_edge_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(q.req_s[1]) && q.ctrl[`CTRL_DEMAND_BIT] |=> q.cal_pend
    ##0 calibrating)
    else $error("calibration request edge lost");

  cal_go_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cal_start |-> (q.st == ST_CAL) && (q.op == OP_FULL) && calibrating)
    else $error("start pulse outside full calibration");

  valid_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rx_data_valid |-> rx_ready && !calibrating && (q.st == ST_LOCKED))
    else $error("data valid while busy or unlocked");

  acq_timeout_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (q.st == ST_ACQ) |-> (q.tmr < LOCK_WAIT_CYC))
    else $error("acquire timer overran");

  eye_done_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (q.st == ST_CAL) && (q.op == OP_EYE) && edone_rise && !eye_rise |=>
      eye_recal_complete && (q.st == ST_LOCKED))
    else $error("eye completion not flagged");

  coeff_done_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (q.st == ST_CAL) && (q.op == OP_COEFF) && kdone_rise && !coeff_rise |=>
      coeff_recal_complete ##1 !coeff_start)
    else $error("coefficient completion not flagged");

  first_lock_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (q.st == ST_ACQ) && lock && q.ctrl[`CTRL_FIRST_BIT] && !q.first_done
      |=> q.cal_pend ##1 cal_start)
    else $error("first lock did not start calibration");

  cal_falls_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (q.st == ST_CAL) && (q.op == OP_FULL) && cdone_rise && !q.eye_pend && !q.coeff_pend
      && !req_rise && !eye_rise && !coeff_rise |=> !calibrating)
    else $error("calibrating stuck after full calibration");

  bresp_a: assert property (@(posedge aclk) disable iff (!aresetn)
    q.aw_have && q.w_have |=> s_axi_bvalid)
    else $error("write response missing");

endmodule : receiver_manager

`default_nettype wire

// *** test/lane_model.sv ***
// far-side model: receive lane lock detector and calibration engines
// assumes start pulses last one aclk cycle; dly sets engine run length
`timescale 1ns/1ps
`default_nettype none

module lane_model (
  input  wire logic       aclk,
  input  wire logic       lock_to_data,
  input  wire logic       present,
  input  wire logic [2:0] start,
  input  wire logic [7:0] dly,
  output logic            fine_lock_in,
  output logic [2:0]      done
);
  logic [7:0] lk   = 8'h00;
  logic [7:0] c    = 8'h00;
  logic [2:0] busy = 3'h0;

  initial begin
    fine_lock_in = 1'b0;
    done         = 3'h0;
  end

  // ----------------------------------------
  // lock window and engines
  // ----------------------------------------
  // fine lock only after a few cycles of lock-to-data with real traffic
  always @(posedge aclk) begin
    lk <= (lock_to_data && present) ? ((lk == 8'hFF) ? lk : lk + 8'h01) : 8'h00;
    fine_lock_in <= (lk > 8'h04);
    if (start != 3'h0) begin
      busy <= start;
      c    <= 8'h00;
      done <= 3'h0;
    end else if (busy != 3'h0) begin
      c <= c + 8'h01;
      if (c == dly) begin
        done <= busy;
        busy <= 3'h0;
      end
    end
  end
endmodule : lane_model

`default_nettype wire

// *** test/receiver_lock_calibration_manager_bench.sv ***
// self-checking bench for the receiver lock and calibration manager
// assumes lane_model stands on the lane side; user requests driven here
`timescale 1ns/1ps
`default_nettype none
`include "rx_manager_cfg.svh"

module receiver_lock_calibration_manager_bench;
  import rx_manager_pkg::*;

  typedef struct packed {
    logic [2:0] req;
    logic [2:0] start;
    logic [1:0] flags;
  } row_s;

  logic            aclk    = 1'b0;
  logic            aresetn = 1'b0;
  logic [3:0]      awaddr  = 4'h0;
  logic [3:0]      araddr  = 4'h0;
  logic [3:0]      wstrb   = 4'h0;
  logic [31:0]     wdata   = 32'h0;
  logic            awvalid = 1'b0;
  logic            wvalid  = 1'b0;
  logic            bready  = 1'b0;
  logic            arvalid = 1'b0;
  logic            rready  = 1'b0;
  logic            loss    = 1'b1;
  logic            act     = 1'b0;
  logic            present = 1'b0;
  logic [2:0]      req     = 3'h0;
  logic [7:0]      dly     = 8'h04;
  logic            awready, wready, bvalid, arready, rvalid;
  logic [1:0]      bresp, rresp;
  logic [31:0]     rdata;
  logic            fine_lock, lock_to_data, calibrating, rx_data_valid, rx_ready;
  logic            rx_no_activity, eye_recal_complete, coeff_recal_complete;
  logic [2:0]      start, done;
  logic [2:0][7:0] cnt     = '0;
  logic [2:0][7:0] base;
  int              err_count = 0;
  int              tests_run = 0;
  int              cyc = 0;
  row_s            rows [3] = '{'{3'h1, 3'h1, 2'h0}, '{3'h2, 3'h2, 2'h1}, '{3'h4, 3'h4, 2'h3}};

  always #2.5 aclk = ~aclk;

  receiver_manager #(.LOCK_WAIT_CYC(`TIMER_W'(20))) DUT (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .signal_loss_in(loss), .cal_request(req[0]), .eye_recal_request(req[1]),
    .coeff_recal_request(req[2]), .peak_activity_in(act), .fine_lock_in(fine_lock),
    .cal_done_in(done[0]), .eye_done_in(done[1]), .coeff_done_in(done[2]),
    .lock_to_data(lock_to_data), .cal_start(start[0]), .eye_start(start[1]),
    .coeff_start(start[2]), .calibrating(calibrating), .rx_data_valid(rx_data_valid),
    .rx_ready(rx_ready), .rx_no_activity(rx_no_activity),
    .eye_recal_complete(eye_recal_complete), .coeff_recal_complete(coeff_recal_complete)
  );

  lane_model lane (
    .aclk(aclk), .lock_to_data(lock_to_data), .present(present), .start(start),
    .dly(dly), .fine_lock_in(fine_lock), .done(done)
  );

  // start pulses stand one cycle, so they are counted rather than sampled
  always @(posedge aclk) begin
    for (int i = 0; i < 3; i++) begin
      if (start[i] === 1'b1) cnt[i] <= cnt[i] + 8'h01;
    end
  end

  // lock may take about three times longer with the manager, ceiling is generous
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      end_sim();
    end
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  function logic sel(input int k);
    return (k == 0) ? lock_to_data : (k == 1) ? calibrating : rx_data_valid;
  endfunction : sel

  task wt(input string nm, input int k, input logic v);
    int n;
    n = 0;
    while (sel(k) !== v && n < 3000) begin
      @(negedge aclk);
      n++;
    end
    chk(nm, v, sel(k));
  endtask : wt

  task axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hF;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 100);
    bready <= 1'b0;
    chk("bvalid", 1, bvalid);
    chk("bresp", r, bresp);
  endtask : axi_wr

  task axi_rd(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 100);
    rready <= 1'b0;
    chk("rvalid", 1, rvalid);
    chk("rdata", d, rdata);
    chk("rresp", r, rresp);
  endtask : axi_rd

  task end_sim;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk("ltd_rst", 0, lock_to_data);
    chk("cal_rst", 0, calibrating);
    chk("val_rst", 0, rx_data_valid);
    chk("idle_rst", 1, rx_no_activity);
    chk("cmp_rst", 0, {eye_recal_complete, coeff_recal_complete});
    axi_rd(`CTRL_OFS, 32'h3, `RESP_OKAY);
    axi_wr(`CTRL_OFS, 32'hF, `RESP_OKAY);
    axi_wr(`STAT_OFS, 32'h0, `RESP_OKAY);
    axi_wr(4'hC, 32'h0, `RESP_SLVERR);
    axi_rd(4'h8, 32'h0, `RESP_SLVERR);
    axi_rd(`CTRL_OFS, 32'hF, `RESP_OKAY);
    @(posedge aclk) act <= 1'b1;
    repeat (40) @(negedge aclk);
    chk("ltd_loss", 0, lock_to_data);
    @(posedge aclk) loss <= 1'b0;
    present <= 1'b1;
    wt("ltd_up", 0, 1);
    wt("auto_cal", 1, 1);
    wt("cal_end", 1, 0);
    chk("auto_cnt", 1, cnt[0]);
    wt("val_up", 2, 1);
    chk("ready", 1, rx_ready);
    chk("activity", 0, rx_no_activity);
    @(posedge aclk) loss <= 1'b1;
    repeat (20) @(negedge aclk);
    chk("ltd_late_loss", 1, lock_to_data);
    @(posedge aclk) loss <= 1'b0;
    foreach (rows[i]) begin
      base = cnt;
      @(posedge aclk) req <= rows[i].req;
      wt("req_cal", 1, 1);
      chk("val_in_cal", 0, rx_data_valid);
      wt("req_end", 1, 0);
      wt("req_val", 2, 1);
      for (int j = 0; j < 3; j++) begin
        chk("starts", 8'(base[j] + rows[i].start[j]), cnt[j]);
      end
      chk("complete", rows[i].flags, {coeff_recal_complete, eye_recal_complete});
      @(posedge aclk) req <= 3'h0;
      repeat (6) @(posedge aclk);
    end
    // slow engine, request held high then re-raised
    dly <= 8'd40;
    base = cnt;
    @(posedge aclk) req <= 3'h1;
    wt("held_cal", 1, 1);
    wt("held_end", 1, 0);
    repeat (60) @(negedge aclk);
    chk("held", 8'(base[0] + 8'h01), cnt[0]);
    @(posedge aclk) req <= 3'h0;
    repeat (4) @(posedge aclk);
    req <= 3'h1;
    wt("again_cal", 1, 1);
    wt("again_end", 1, 0);
    chk("again", 8'(base[0] + 8'h02), cnt[0]);
    @(posedge aclk) req <= 3'h0;
    base = cnt;
    // on-demand disabled: a fresh request edge must be ignored
    axi_wr(`CTRL_OFS, 32'hD, `RESP_OKAY);
    @(posedge aclk) req <= 3'h1;
    repeat (20) @(negedge aclk);
    chk("no_demand", base[0], cnt[0]);
    chk("no_demand_cal", 0, calibrating);
    @(posedge aclk) req <= 3'h0;
    @(posedge aclk) present <= 1'b0;
    wt("pull_val", 2, 0);
    wt("pull_ltd", 0, 0);
    @(posedge aclk) present <= 1'b1;
    wt("relock_val", 2, 1);
    chk("no_auto", base[0], cnt[0]);
    end_sim();
  end
endmodule : receiver_lock_calibration_manager_bench

`default_nettype wire
